// *** rtl/phy_regs_map.svh ***
// Purpose: register indices, field positions, reset values and timing counts
// Assumes: word index i sits at byte address 4*i on the register bus
// Notes:   definitions only
`ifndef PHY_REGS_MAP_SVH
`define PHY_REGS_MAP_SVH

`define IDX_FCTL       5'h00
`define IDX_CC2        5'h14
`define IDX_RXERR      5'h15
`define IDX_PAGE       5'h16
`define IDX_GINT       5'h17
`define IDX_ISTAT      5'h1d
`define IDX_IMASK      5'h1e

`define PAGE_COPPER    8'h00
`define PAGE_FIBER     8'h01

`define CC2_RST        16'h0020
`define CC2_KEEP_LINK  6
`define FC_RESET       15
`define FC_LPBK        14
`define FC_SPD_LSB     13
`define FC_SPD_MSB     6
`define SPD_MSB_RST    1'b1
`define SPD_LSB_RST    1'b0

`define MODE_100FX     2'b00
`define MODE_1000X     2'b01
`define MODE_AUTO      2'b10
`define MODE_RW        2'b11

`define RXERR_MAX      16'hffff

`define IRQ_W          3
`define IRQ_FC         0
`define IRQ_SE         1
`define IRQ_FRST       2

`define CLK_PERIOD_NS  5
`define FIBER_RST_NS   80
`define FIBER_RST_CYC  ((`FIBER_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/phy_regs_pkg.sv ***
// Purpose: types shared by the management register slice
// Assumes: phy_regs_map.svh supplies widths
// Notes:   apb field names kept as published
package phy_regs_pkg;
  `include "phy_regs_map.svh"

  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000, SPD_RSVD} speed_e;
  typedef enum logic {FR_IDLE, FR_BUSY} frst_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic false_carrier;
    logic symbol_error;
  } rx_err_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } lb_data_s;

  typedef struct packed {
    logic [15:0] cnt;
  } cnt_state_s;

  typedef struct packed {
    frst_state_e st;
    logic [4:0]  cnt;
    logic        busy;
    logic        done;
  } frst_state_s;

  typedef struct packed {
    apb_rsp_s           rsp;
    logic [15:0]        cc2;
    logic [7:0]         page;
    logic [`IRQ_W-1:0]  int_st;
    logic [`IRQ_W-1:0]  int_mask;
    logic               irq;
    logic               lpbk;
    logic               spd_msb;
    logic               spd_lsb;
    speed_e             speed;
    lb_data_s           rx_out;
  } regs_state_s;
endpackage

// *** rtl/rx_error_counter.sv ***
// Purpose: saturating receive error counter, cleared by a read
// Assumes: error strobes come from logic on core_clk
// Notes:   an error in the clearing cycle is kept
`include "phy_regs_map.svh"
module rx_error_counter
  import phy_regs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire rx_err_s     err,
  input  wire logic        clear_rd,
  output logic      [15:0] count
);
  cnt_state_s s_q;
  cnt_state_s s_d;
  logic [1:0] inc;

  function automatic logic [15:0] sat_add(input logic [15:0] v, input logic [1:0] n);
    logic [16:0] sum;
    sum = {1'b0, v} + {15'h0000, n};
    sat_add = sum[16] ? `RXERR_MAX : sum[15:0];
  endfunction

  always_comb begin
    s_d = s_q;
    inc = {1'b0, err.false_carrier} + {1'b0, err.symbol_error};
    s_d.cnt = sat_add(clear_rd ? 16'h0000 : s_q.cnt, inc);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_CNT_SAT: assert property (
    count == `RXERR_MAX && !clear_rd |=> count == `RXERR_MAX)
    else $error("error counter left its ceiling");
  AST_CNT_INC: assert property (
    !clear_rd && count < 16'hfffe |=> count == 16'($past(count) + {14'h0, $past(inc)}))
    else $error("error counter missed an event");
  AST_CNT_CLR: assert property (
    clear_rd && !err.false_carrier && !err.symbol_error |=> count == 16'h0000)
    else $error("error counter not cleared by read");
  COV_CNT_PEG: cover property (count == `RXERR_MAX);
endmodule // rx_error_counter

// *** rtl/fiber_reset_seq.sv ***
// Purpose: self-clearing fiber soft reset sequencer
// Assumes: start is a one-cycle write strobe
// Notes:   starts while busy are ignored
`include "phy_regs_map.svh"
module fiber_reset_seq
  import phy_regs_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  frst_state_s s_q;
  frst_state_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      FR_IDLE: begin
        if (start) begin
          s_d.st   = FR_BUSY;
          s_d.busy = 1'b1;
          s_d.cnt  = 5'(`FIBER_RST_CYC - 1);
        end
      end
      FR_BUSY: begin
        if (s_q.cnt == 5'h00) begin
          s_d.st   = FR_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 5'h01;
        end
      end
      default: begin
        s_d = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_FRST_GO: assert property (
    start && !busy |=> busy)
    else $error("fiber reset did not start at once");
  AST_FRST_LEN: assert property (
    $rose(busy) |-> ##15 busy ##1 (!busy && done))
    else $error("fiber reset length wrong or bit not cleared");
  COV_FRST: cover property ($fell(busy));
endmodule // fiber_reset_seq

// *** rtl/phy_copper_fiber_ctrl_regs.sv ***
// Purpose: copper control 2, rx error count, page, global irq, fiber control
// Assumes: apb slave, no wait states; event inputs from core_clk logic
// Notes:   byte address = 4 * register index
//
// The APB slave port is this design's own decision.

`include "phy_regs_map.svh"
module phy_copper_fiber_ctrl_regs
  import phy_regs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire apb_req_s   apb_req,
  output apb_rsp_s        apb_rsp,
  input  wire rx_err_s    rx_err,
  input  wire logic [1:0] fiber_mode,
  input  wire logic       fiber_at_1000,
  input  wire logic       fiber_at_100,
  input  wire lb_data_s   int_tx,
  input  wire lb_data_s   line_rx,
  output lb_data_s        int_rx,
  output logic            keep_link_on_short_ipg,
  output logic [3:0]      tx_polarity_invert,
  output logic            fiber_sm_reset,
  output logic            fiber_loopback,
  output logic            fiber_line_link_break,
  output speed_e          fiber_speed,
  output logic [7:0]      page_sel,
  output logic            irq
);
  // ****************************************
  // declarations
  // ****************************************
  regs_state_s        s_q;
  regs_state_s        s_d;
  logic               setup;
  logic               acc;
  logic               hit;
  logic               wr_en;
  logic [4:0]         idx;
  logic               clr_rd;
  logic               frst_go;
  logic               frst_busy;
  logic               frst_done;
  logic [15:0]        err_cnt;
  logic               msb_eff;
  logic               lsb_eff;
  logic [`IRQ_W-1:0]  ev;
  logic [`IRQ_W-1:0]  w1c;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] pg);
    logic [4:0] i;
    i = a[6:2];
    reg_hit = (a[11:7] == 5'h00) && (a[1:0] == 2'b00) &&
              (i == `IDX_PAGE || i == `IDX_ISTAT || i == `IDX_IMASK ||
               (pg == `PAGE_COPPER &&
                (i == `IDX_CC2 || i == `IDX_RXERR || i == `IDX_GINT)) ||
               (pg == `PAGE_FIBER && i == `IDX_FCTL));
  endfunction

  function automatic logic spd_bit(input logic [1:0] m, input logic live,
                                   input logic stored, input logic c00);
    case (m)
      `MODE_100FX: spd_bit = c00;
      `MODE_1000X: spd_bit = ~c00;
      `MODE_AUTO:  spd_bit = live;
      default:     spd_bit = stored;
    endcase
  endfunction

  function automatic speed_e speed_of(input logic msb, input logic lsb);
    case ({msb, lsb})
      2'b10:   speed_of = SPD_1000;
      2'b01:   speed_of = SPD_100;
      2'b00:   speed_of = SPD_10;
      default: speed_of = SPD_RSVD;
    endcase
  endfunction

  // ****************************************
  // submodules
  // ****************************************
  rx_error_counter u_rx_err (
    .core_clk (core_clk),
    .resetn   (resetn),
    .err      (rx_err),
    .clear_rd (clr_rd),
    .count    (err_cnt)
  );

  fiber_reset_seq u_frst (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (frst_go),
    .busy     (frst_busy),
    .done     (frst_done)
  );

  // ****************************************
  // register file
  // ****************************************
  always_comb begin
    s_d     = s_q;
    setup   = apb_req.psel & ~apb_req.penable;
    acc     = apb_req.psel & apb_req.penable & s_q.rsp.pready;
    idx     = apb_req.paddr[6:2];
    hit     = reg_hit(apb_req.paddr, s_q.page);
    wr_en   = acc & apb_req.pwrite & hit;
    clr_rd  = setup & ~apb_req.pwrite & hit & (idx == `IDX_RXERR) &
              (s_q.page == `PAGE_COPPER);
    frst_go = wr_en & (idx == `IDX_FCTL) & (s_q.page == `PAGE_FIBER) &
              apb_req.pwdata[`FC_RESET];
    msb_eff = spd_bit(fiber_mode, fiber_at_1000, s_q.spd_msb, 1'b0);
    lsb_eff = spd_bit(fiber_mode, fiber_at_100, s_q.spd_lsb, 1'b1);
    ev      = '0;
    w1c     = '0;
    ev[`IRQ_FC]   = rx_err.false_carrier;
    ev[`IRQ_SE]   = rx_err.symbol_error;
    ev[`IRQ_FRST] = frst_done;

    // no wait state: answer registered in setup, shown in access
    s_d.rsp.pready = setup;
    if (setup) begin
      s_d.rsp.pslverr = ~hit;
      s_d.rsp.prdata  = '0;
      if (hit & ~apb_req.pwrite) begin
        if (idx == `IDX_PAGE) begin
          s_d.rsp.prdata = {24'h000000, s_q.page};
        end else if (idx == `IDX_ISTAT) begin
          s_d.rsp.prdata[`IRQ_W-1:0] = s_q.int_st;
        end else if (idx == `IDX_IMASK) begin
          s_d.rsp.prdata[`IRQ_W-1:0] = s_q.int_mask;
        end else if (idx == `IDX_CC2) begin
          s_d.rsp.prdata[15:0] = s_q.cc2;
        end else if (idx == `IDX_RXERR) begin
          s_d.rsp.prdata[15:0] = err_cnt;
        end else if (idx == `IDX_GINT) begin
          s_d.rsp.prdata[0] = s_q.irq;
        end else begin
          s_d.rsp.prdata[`FC_RESET]   = frst_busy;
          s_d.rsp.prdata[`FC_LPBK]    = s_q.lpbk;
          s_d.rsp.prdata[`FC_SPD_LSB] = lsb_eff;
          s_d.rsp.prdata[`FC_SPD_MSB] = msb_eff;
        end
      end
    end else if (acc) begin
      s_d.rsp.pslverr = 1'b0;
    end

    if (wr_en) begin
      if (idx == `IDX_PAGE) begin
        s_d.page = apb_req.pwdata[7:0];
      end else if (idx == `IDX_ISTAT) begin
        w1c = apb_req.pwdata[`IRQ_W-1:0];
      end else if (idx == `IDX_IMASK) begin
        s_d.int_mask = apb_req.pwdata[`IRQ_W-1:0];
      end else if (idx == `IDX_CC2) begin
        s_d.cc2 = apb_req.pwdata[15:0];
      end else if (idx == `IDX_FCTL) begin
        s_d.lpbk = apb_req.pwdata[`FC_LPBK];
        if (fiber_mode == `MODE_RW) begin
          s_d.spd_msb = apb_req.pwdata[`FC_SPD_MSB];
          s_d.spd_lsb = apb_req.pwdata[`FC_SPD_LSB];
        end
      end
    end
    if (frst_busy) begin
      s_d.lpbk = 1'b0;
    end

    // set wins over clear
    s_d.int_st = (s_q.int_st & ~w1c) | ev;
    s_d.irq    = |(s_q.int_st & s_q.int_mask);

    // ****************************************
    // fiber speed and loopback path
    // ****************************************
    if (s_q.lpbk && fiber_mode == `MODE_1000X) begin
      s_d.speed = SPD_1000;
    end else if (s_q.lpbk && fiber_mode == `MODE_100FX) begin
      s_d.speed = SPD_100;
    end else begin
      s_d.speed = speed_of(msb_eff, lsb_eff);
    end
    s_d.rx_out = s_q.lpbk ? int_tx : line_rx;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q         <= '0;
      s_q.cc2     <= `CC2_RST;
      s_q.page    <= `PAGE_COPPER;
      s_q.spd_msb <= `SPD_MSB_RST;
      s_q.spd_lsb <= `SPD_LSB_RST;
      s_q.speed   <= SPD_10;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign apb_rsp                = s_q.rsp;
  assign keep_link_on_short_ipg = s_q.cc2[`CC2_KEEP_LINK];
  assign tx_polarity_invert     = s_q.cc2[3:0];
  assign fiber_sm_reset         = frst_busy;
  assign fiber_loopback         = s_q.lpbk;
  assign fiber_line_link_break  = s_q.lpbk;
  assign fiber_speed            = s_q.speed;
  assign int_rx                 = s_q.rx_out;
  assign page_sel               = s_q.page;
  assign irq                    = s_q.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_KEEP_LINK: assert property (
    wr_en && idx == `IDX_CC2 |=> keep_link_on_short_ipg == $past(apb_req.pwdata[6]))
    else $error("link break control not taken from write");
  AST_POLARITY: assert property (
    wr_en && idx == `IDX_CC2 |=> tx_polarity_invert == $past(apb_req.pwdata[3:0]))
    else $error("pair polarity not taken from write");
  AST_PAGE_RD: assert property (
    setup && !apb_req.pwrite && hit && idx == `IDX_PAGE
    |=> apb_rsp.pready && apb_rsp.prdata == {24'h000000, $past(page_sel)})
    else $error("page read wrong");
  AST_GINT_RD: assert property (
    setup && !apb_req.pwrite && hit && idx == `IDX_GINT
    |=> apb_rsp.prdata == {31'h0, $past(irq)})
    else $error("global interrupt bit wrong");
  AST_IRQ: assert property (
    (s_q.int_st & s_q.int_mask) != '0 |=> irq)
    else $error("interrupt not raised");
  AST_LOOPBACK: assert property (
    fiber_loopback |-> fiber_line_link_break ##1 int_rx == $past(int_tx))
    else $error("loopback data or link break wrong");
  AST_LB_SPEED: assert property (
    fiber_loopback && fiber_mode == `MODE_1000X |=> fiber_speed == SPD_1000)
    else $error("loopback speed not 1000");
  AST_LB_SPEED100: assert property (
    fiber_loopback && fiber_mode == `MODE_100FX |=> fiber_speed == SPD_100)
    else $error("loopback speed not 100");
  AST_FRST_BIT: assert property (
    setup && !apb_req.pwrite && hit && idx == `IDX_FCTL && frst_busy
    |=> apb_rsp.prdata[`FC_RESET])
    else $error("fiber reset bit not shown while busy");
  AST_FRST_LPBK: assert property (
    frst_busy |=> !fiber_loopback)
    else $error("loopback kept during fiber reset");
  AST_MODE00_RD: assert property (
    setup && !apb_req.pwrite && hit && idx == `IDX_FCTL && fiber_mode == `MODE_100FX
    |=> apb_rsp.prdata[13] && !apb_rsp.prdata[6])
    else $error("speed bits wrong in mode 00");
  AST_MODE01_RD: assert property (
    setup && !apb_req.pwrite && hit && idx == `IDX_FCTL && fiber_mode == `MODE_1000X
    |=> !apb_rsp.prdata[13] && apb_rsp.prdata[6])
    else $error("speed bits wrong in mode 01");
  AST_MODE10_RD: assert property (
    setup && !apb_req.pwrite && hit && idx == `IDX_FCTL && fiber_mode == `MODE_AUTO
    |=> apb_rsp.prdata[13] == $past(fiber_at_100) &&
        apb_rsp.prdata[6] == $past(fiber_at_1000))
    else $error("speed bits do not follow live speed in mode 10");
  AST_SPD_RW: assert property (
    wr_en && idx == `IDX_FCTL && fiber_mode == `MODE_RW
    |=> s_q.spd_lsb == $past(apb_req.pwdata[`FC_SPD_LSB]) &&
        s_q.spd_msb == $past(apb_req.pwdata[`FC_SPD_MSB]))
    else $error("speed bits not written in mode 11");
  AST_SPD_DEC: assert property (
    !fiber_loopback && fiber_mode == `MODE_RW && s_q.spd_msb && !s_q.spd_lsb
    |=> fiber_speed == SPD_1000)
    else $error("speed decode wrong");
  AST_RD_CLR: assert property (
    clr_rd |-> ##1 apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("counter read did not complete");
  AST_UNMAPPED: assert property (
    setup && !hit |=> apb_rsp.pready && apb_rsp.pslverr)
    else $error("unmapped access not flagged");
  AST_SET_WINS: assert property (
    wr_en && idx == `IDX_ISTAT && apb_req.pwdata[`IRQ_FC] && rx_err.false_carrier
    |=> s_q.int_st[`IRQ_FC])
    else $error("false carrier event lost to clear");
  AST_PREADY_ONE: assert property (
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held longer than one cycle");

  COV_LOOPBACK: cover property ($rose(fiber_loopback));
  COV_IRQ:      cover property ($rose(irq));
  COV_ERR:      cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule // phy_copper_fiber_ctrl_regs

// *** testbench/mgmt_master.sv ***
// Purpose: management controller model, apb master on the register port
// Assumes: the slave answers with pready; the bench bounds every wait
// Notes:   one transfer at a time, one idle cycle between transfers
module mgmt_master
  import phy_regs_pkg::*;
(
  input  wire logic     core_clk,
  output apb_req_s      req,
  input  wire apb_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] wd,
                      output logic [15:0] rd, output logic err);
    @(posedge core_clk);
    req.psel    <= 1'h1;
    req.penable <= 1'h0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= {16'h0000, wd};
    @(posedge core_clk);
    req.penable <= 1'h1;
    @(posedge core_clk);
    while (rsp.pready !== 1'h1) @(posedge core_clk);
    rd = rsp.prdata[15:0];
    err = rsp.pslverr;
    req.psel    <= 1'h0;
    req.penable <= 1'h0;
  endtask
endmodule // mgmt_master

// *** testbench/test_phy_copper_fiber_ctrl_regs.sv ***
// Purpose: self-checking bench of the management register slice
// Assumes: apb slave with no wait states, byte address is four times the index
// Notes:   register table rows first, then hand-written cases
`include "phy_regs_map.svh"
module test_phy_copper_fiber_ctrl_regs
  import phy_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic wr; logic [11:0] a; logic [15:0] wd; logic [15:0] exp; logic err;
  } row_s;
  typedef struct packed {
    logic [1:0] m; logic a1; logic a2; logic [15:0] exp; speed_e sp;
  } mrow_s;

  logic        core_clk, resetn, fiber_at_1000, fiber_at_100, irq;
  logic        keep_link, lb, lbrk, fsm_rst;
  logic [1:0]  fiber_mode;
  logic [3:0]  pol;
  logic [7:0]  page_sel;
  logic [15:0] rd;
  logic        err;
  apb_req_s    apb_req;
  apb_rsp_s    apb_rsp;
  rx_err_s     rx_err;
  lb_data_s    int_tx, line_rx, int_rx;
  speed_e      fiber_speed;
  int          fail_count, compares, cyc, n;

  row_s rows [11] = '{
    '{1'h0, 12'h058, 16'h0000, 16'h0000, 1'h0},
    '{1'h0, 12'h050, 16'h0000, 16'h0020, 1'h0},
    '{1'h1, 12'h050, 16'h0065, 16'h0000, 1'h0},
    '{1'h0, 12'h050, 16'h0000, 16'h0065, 1'h0},
    '{1'h0, 12'h054, 16'h0000, 16'h0000, 1'h0},
    '{1'h0, 12'h05c, 16'h0000, 16'h0000, 1'h0},
    '{1'h0, 12'h000, 16'h0000, 16'h0000, 1'h1},
    '{1'h1, 12'h058, 16'h0301, 16'h0000, 1'h0},
    '{1'h0, 12'h058, 16'h0000, 16'h0001, 1'h0},
    '{1'h0, 12'h050, 16'h0000, 16'h0000, 1'h1},
    '{1'h0, 12'h000, 16'h0000, 16'h0040, 1'h0}
  };
  mrow_s mrows [6] = '{
    '{2'h0, 1'h0, 1'h0, 16'h2000, SPD_100},
    '{2'h1, 1'h0, 1'h0, 16'h0040, SPD_1000},
    '{2'h2, 1'h1, 1'h0, 16'h0040, SPD_1000},
    '{2'h2, 1'h0, 1'h1, 16'h2000, SPD_100},
    '{2'h2, 1'h0, 1'h0, 16'h0000, SPD_10},
    '{2'h3, 1'h0, 1'h0, 16'h0040, SPD_1000}
  };

  mgmt_master u_mst (.core_clk(core_clk), .req(apb_req), .rsp(apb_rsp));

  phy_copper_fiber_ctrl_regs dut (
    .core_clk(core_clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .rx_err(rx_err), .fiber_mode(fiber_mode), .fiber_at_1000(fiber_at_1000),
    .fiber_at_100(fiber_at_100), .int_tx(int_tx), .line_rx(line_rx), .int_rx(int_rx),
    .keep_link_on_short_ipg(keep_link), .tx_polarity_invert(pol),
    .fiber_sm_reset(fsm_rst), .fiber_loopback(lb), .fiber_line_link_break(lbrk),
    .fiber_speed(fiber_speed), .page_sel(page_sel), .irq(irq)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rw(input logic wr, input logic [11:0] a, input logic [15:0] wd,
                    input logic [15:0] exp, input logic eerr);
    u_mst.xfer(wr, a, wd, rd, err);
    check("pslverr", err, eerr);
    if (!wr) check("prdata", rd, exp);
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wait2;
    repeat (2) @(posedge core_clk);
  endtask

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 50000) begin
      fail_count++;
      results();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    resetn = 1'h0;
    rx_err = '0;
    fiber_mode = 2'h3;
    fiber_at_1000 = 1'h0;
    fiber_at_100 = 1'h0;
    int_tx = '0;
    line_rx = '0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'h1;
    foreach (rows[i]) rw(rows[i].wr, rows[i].a, rows[i].wd, rows[i].exp, rows[i].err);
    check("keep_link", keep_link, 1'h1);
    check("polarity", pol, 4'h5);
    check("page_sel", page_sel, 8'h01);
    foreach (mrows[i]) begin
      fiber_mode <= mrows[i].m;
      fiber_at_1000 <= mrows[i].a1;
      fiber_at_100 <= mrows[i].a2;
      wait2();
      check("fiber_speed", fiber_speed, mrows[i].sp);
      rw(1'h0, 12'h000, 16'h0000, mrows[i].exp, 1'h0);
    end
    rw(1'h1, 12'h000, 16'h2000, 16'h0000, 1'h0);
    rw(1'h0, 12'h000, 16'h0000, 16'h2000, 1'h0);
    check("fiber_speed", fiber_speed, SPD_100);
    rw(1'h1, 12'h000, 16'h0000, 16'h0000, 1'h0);
    wait2();
    check("fiber_speed", fiber_speed, SPD_10);
    fiber_mode <= 2'h1;
    int_tx <= '{1'h1, 8'ha5};
    line_rx <= '{1'h1, 8'h3c};
    rw(1'h1, 12'h000, 16'h4000, 16'h0000, 1'h0);
    wait2();
    check("loopback", {lb, lbrk}, 2'h3);
    check("int_rx", int_rx, 9'h1a5);
    check("fiber_speed", fiber_speed, SPD_1000);
    fiber_mode <= 2'h0;
    wait2();
    check("fiber_speed", fiber_speed, SPD_100);
    rw(1'h1, 12'h000, 16'h0000, 16'h0000, 1'h0);
    wait2();
    check("loopback", {lb, lbrk}, 2'h0);
    check("int_rx", int_rx, 9'h13c);
    rw(1'h1, 12'h000, 16'h8000, 16'h0000, 1'h0);
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      if (fsm_rst === 1'h1) n++;
    end
    check("reset_cycles", n, `FIBER_RST_CYC);
    rw(1'h0, 12'h000, 16'h0000, 16'h2000, 1'h0);
    rw(1'h1, 12'h000, 16'h8000, 16'h0000, 1'h0);
    rw(1'h0, 12'h000, 16'h0000, 16'ha000, 1'h0);
    repeat (20) @(posedge core_clk);
    rw(1'h1, 12'h058, 16'h0000, 16'h0000, 1'h0);
    rx_err <= 2'b10;
    @(posedge core_clk);
    rx_err <= 2'b11;
    @(posedge core_clk);
    rx_err <= 2'b01;
    @(posedge core_clk);
    rx_err <= 2'b00;
    rw(1'h0, 12'h054, 16'h0000, 16'h0004, 1'h0);
    rw(1'h0, 12'h054, 16'h0000, 16'h0000, 1'h0);
    rw(1'h0, 12'h074, 16'h0000, 16'h0007, 1'h0);
    check("irq", irq, 1'h0);
    rw(1'h1, 12'h078, 16'h0001, 16'h0000, 1'h0);
    wait2();
    check("irq", irq, 1'h1);
    rw(1'h0, 12'h05c, 16'h0000, 16'h0001, 1'h0);
    rw(1'h1, 12'h074, 16'h0001, 16'h0000, 1'h0);
    wait2();
    check("irq", irq, 1'h0);
    rw(1'h0, 12'h05c, 16'h0000, 16'h0000, 1'h0);
    rw(1'h0, 12'h074, 16'h0000, 16'h0006, 1'h0);
    rx_err <= 2'b11;
    repeat (32768) @(posedge core_clk);
    rx_err <= 2'b00;
    rw(1'h0, 12'h054, 16'h0000, 16'hffff, 1'h0);
    rw(1'h0, 12'h054, 16'h0000, 16'h0000, 1'h0);
    rx_err <= 2'b10;
    rw(1'h1, 12'h074, 16'h0001, 16'h0000, 1'h0);
    rx_err <= 2'b00;
    rw(1'h0, 12'h074, 16'h0000, 16'h0007, 1'h0);
    check("irq", irq, 1'h1);
    @(posedge core_clk);
    resetn <= 1'h0;
    wait2();
    check("reset_outs", {keep_link, pol, page_sel, irq}, 14'h0000);
    resetn <= 1'h1;
    rw(1'h0, 12'h050, 16'h0000, 16'h0020, 1'h0);
    rw(1'h0, 12'h058, 16'h0000, 16'h0000, 1'h0);
    rw(1'h0, 12'h054, 16'h0000, 16'h0000, 1'h0);
    results();
  end
endmodule // test_phy_copper_fiber_ctrl_regs
